// file: logic/crc16_byte_engine.sv
// Added by the designer: register access over Avalon-MM and the register offsets.
`timescale 1ns/1ps
module crc16_byte_engine (
	input wire logic clock_i, // System clock, 50 MHz
	input wire logic reset_i, // Synchronous reset, high
	input wire logic [4:0] address_i, // Avalon byte address
	input wire logic read_i, // Avalon read
	input wire logic write_i, // Avalon write
	input wire logic [31:0] writedata_i, // Avalon write data
	input wire logic [3:0] byteenable_i, // Avalon byte enables
	output logic [31:0] readdata_o, // Avalon read data
	output logic [1:0] response_o, // Avalon response code
	output logic waitrequest_o // Avalon waitrequest
);
	// Register state
	logic [7:0] byte_input;
	logic [7:0] sum_low;
	logic [7:0] sum_high;
	logic generator_select;
	logic [7:0] update_count;

	// Next values
	logic [7:0] next_byte_input;
	logic [7:0] next_sum_low;
	logic [7:0] next_sum_high;
	logic next_generator_select;
	logic [7:0] next_update_count;
	logic [31:0] next_readdata;
	logic [1:0] next_response;

	// Handshake strobes
	wire capture;
	wire accept;

	// Address decode
	wire hit_byte_input;
	wire hit_sum_low;
	wire hit_sum_high;
	wire hit_gen_control;
	wire hit_update_count;
	wire hit_any;
	wire lane0;

	// Write strobes per register
	wire wr_byte_input;
	wire wr_sum_low;
	wire wr_sum_high;
	wire wr_gen_control;
	wire [7:0] write_byte;

	// Read selection
	wire [7:0] read_byte;
	wire [31:0] read_word;

	// Update datapath
	wire [15:0] running_checksum;
	wire [15:0] updated_checksum;

	crc_calc_if calc ();

	// Bus timing lives apart from the register file
	crc_bus_handshake handshake (
		.clock_i(clock_i),
		.reset_i(reset_i),
		.read_i(read_i),
		.write_i(write_i),
		.capture_o(capture),
		.accept_o(accept),
		.waitrequest_o(waitrequest_o)
	);

	// Combinational eight-step fold, done in one cycle
	crc_byte_update fold (
		.calc(calc.engine)
	);

	// Checksum as one 16-bit word
	assign running_checksum = {sum_high, sum_low};

	// Feed the folder from the live registers and the write data
	assign calc.sum_in = running_checksum;
	assign calc.data_in = write_byte;
	assign calc.generator_select = generator_select;
	assign updated_checksum = calc.sum_out;

	// Decode full address so aliases do not appear
	assign hit_byte_input = (address_i == crc_pkg::OFS_BYTE_INPUT);
	assign hit_sum_low = (address_i == crc_pkg::OFS_SUM_LOW);
	assign hit_sum_high = (address_i == crc_pkg::OFS_SUM_HIGH);
	assign hit_gen_control = (address_i == crc_pkg::OFS_GEN_CONTROL);
	assign hit_update_count = (address_i == crc_pkg::OFS_UPDATE_COUNT);
	assign hit_any = hit_byte_input | hit_sum_low | hit_sum_high | hit_gen_control | hit_update_count;

	// Registers are 8 bits wide; only lane 0 carries them
	assign lane0 = byteenable_i[crc_pkg::BYTE_LANE0_BIT];
	assign write_byte = writedata_i[7:0];

	// A write takes effect only at the accepting edge
	assign wr_byte_input = accept & write_i & lane0 & hit_byte_input;
	assign wr_sum_low = accept & write_i & lane0 & hit_sum_low;
	assign wr_sum_high = accept & write_i & lane0 & hit_sum_high;
	assign wr_gen_control = accept & write_i & lane0 & hit_gen_control;

	// Read mux; unused control bits and upper lanes read zero
	assign read_byte = hit_byte_input ? byte_input :
		hit_sum_low ? sum_low :
		hit_sum_high ? sum_high :
		hit_gen_control ? {7'h00, generator_select} :
		hit_update_count ? update_count :
		8'h00;
	assign read_word = {24'h000000, read_byte};

	// Input byte register
	always_comb
	begin
		next_byte_input = byte_input;
		if (wr_byte_input)
			next_byte_input = write_byte;
	end

	// Checksum pair: direct writes, or the folded result on an input write
	always_comb
	begin
		next_sum_low = sum_low;
		next_sum_high = sum_high;
		if (wr_byte_input)
		begin
			next_sum_high = updated_checksum[15:8];
			next_sum_low = updated_checksum[7:0];
		end
		else
		begin
			if (wr_sum_low)
				next_sum_low = write_byte;
			if (wr_sum_high)
				next_sum_high = write_byte;
		end
	end

	// Generator select; only bit 0 is stored
	always_comb
	begin
		next_generator_select = generator_select;
		if (wr_gen_control)
			next_generator_select = writedata_i[crc_pkg::GEN_SELECT_BIT];
	end

	// Bytes folded since the checksum was last written; wraps at 255
	always_comb
	begin
		next_update_count = update_count;
		if (wr_byte_input)
			next_update_count = update_count + 8'h01;
		else if (wr_sum_low | wr_sum_high)
			next_update_count = crc_pkg::UPDATE_COUNT_RESET;
	end

	// Read data sampled at request start, steady through the answer
	always_comb
	begin
		next_readdata = readdata_o;
		next_response = response_o;
		if (capture)
		begin
			next_readdata = read_i ? read_word : 32'h00000000;
			next_response = hit_any ? crc_pkg::RESP_OKAY : crc_pkg::RESP_SLAVEERROR;
		end
	end

	// Register file flip-flops
	always_ff @(posedge clock_i)
	begin
		if (reset_i)
		begin
			byte_input <= crc_pkg::BYTE_INPUT_RESET;
			sum_low <= crc_pkg::SUM_LOW_RESET;
			sum_high <= crc_pkg::SUM_HIGH_RESET;
			generator_select <= crc_pkg::GEN_SELECT_RESET;
			update_count <= crc_pkg::UPDATE_COUNT_RESET;
		end
		else
		begin
			byte_input <= next_byte_input;
			sum_low <= next_sum_low;
			sum_high <= next_sum_high;
			generator_select <= next_generator_select;
			update_count <= next_update_count;
		end
	end

	// Bus answer flip-flops
	always_ff @(posedge clock_i)
	begin
		if (reset_i)
		begin
			readdata_o <= 32'h00000000;
			response_o <= crc_pkg::RESP_OKAY;
		end
		else
		begin
			readdata_o <= next_readdata;
			response_o <= next_response;
		end
	end
endmodule

// file: shared/crc_pkg.sv
package crc_pkg;
	// Avalon byte addresses of the register words
	localparam int unsigned ADDR_W = 5;
	localparam logic [4:0] OFS_BYTE_INPUT = 5'h00;
	localparam logic [4:0] OFS_SUM_LOW = 5'h04;
	localparam logic [4:0] OFS_SUM_HIGH = 5'h08;
	localparam logic [4:0] OFS_GEN_CONTROL = 5'h0c;
	localparam logic [4:0] OFS_UPDATE_COUNT = 5'h10;

	// Field layout
	localparam int unsigned GEN_SELECT_BIT = 0;
	localparam int unsigned BYTE_LANE0_BIT = 0;

	// Reset values
	localparam logic [7:0] BYTE_INPUT_RESET = 8'h00;
	localparam logic [7:0] SUM_LOW_RESET = 8'h00;
	localparam logic [7:0] SUM_HIGH_RESET = 8'h00;
	localparam logic GEN_SELECT_RESET = 1'b0;
	localparam logic [7:0] UPDATE_COUNT_RESET = 8'h00;

	// Generator selection and its xor patterns
	localparam logic GEN_CCITT = 1'b0;
	localparam logic GEN_CRC16 = 1'b1;
	localparam logic [15:0] GENERATOR_SELECT_CCITT = 16'h1021;
	localparam logic [15:0] GENERATOR_SELECT_CRC16 = 16'h8005;
	localparam int unsigned BITS_PER_BYTE = 8;

	// Avalon response codes
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLAVEERROR = 2'h2;

	// Timing: cycles from request to the waitrequest-low edge
	localparam int unsigned ANSWER_CYCLES = 1;

	typedef enum logic [0:0] {
		BUS_IDLE = 1'b0,
		BUS_ANSWER = 1'b1
	} bus_state_e;
endpackage

// file: shared/crc_calc_if.sv
`timescale 1ns/1ps
interface crc_calc_if;
	logic [15:0] sum_in;
	logic [7:0] data_in;
	logic generator_select;
	logic [15:0] sum_out;

	modport requester (output sum_in, output data_in, output generator_select, input sum_out);
	modport engine (input sum_in, input data_in, input generator_select, output sum_out);
endinterface

// file: logic/crc_byte_update.sv
`timescale 1ns/1ps
module crc_byte_update (
	crc_calc_if.engine calc // Sum, byte and generator in, new sum out
);
	logic [15:0] stage [0:crc_pkg::BITS_PER_BYTE];
	wire [15:0] generator_select_pattern;

	// Only two patterns exist, chosen by one bit
	assign generator_select_pattern = (calc.generator_select == crc_pkg::GEN_CRC16) ? crc_pkg::GENERATOR_SELECT_CRC16 : crc_pkg::GENERATOR_SELECT_CCITT;

	// Byte folds into the high half, low half kept
	assign stage[0] = {calc.sum_in[15:8] ^ calc.data_in, calc.sum_in[7:0]};

	// One shift and conditional xor per input bit
	genvar i;
	generate
		for (i = 0; i < crc_pkg::BITS_PER_BYTE; i++)
		begin : bit_step
			wire [15:0] shifted;
			assign shifted = {stage[i][14:0], 1'b0};
			assign stage[i + 1] = stage[i][15] ? (shifted ^ generator_select_pattern) : shifted;
		end
	endgenerate

	// Zero sum with byte 01h leaves exactly the xor pattern
	assign calc.sum_out = stage[crc_pkg::BITS_PER_BYTE];
endmodule

// file: logic/crc_bus_handshake.sv
`timescale 1ns/1ps
module crc_bus_handshake (
	input wire logic clock_i, // System clock
	input wire logic reset_i, // Synchronous reset, high
	input wire logic read_i, // Avalon read request
	input wire logic write_i, // Avalon write request
	output logic capture_o, // First cycle of a request
	output logic accept_o, // Edge at which the access completes
	output logic waitrequest_o // Avalon waitrequest
);
	crc_pkg::bus_state_e state;
	crc_pkg::bus_state_e next_state;
	wire request;

	assign request = read_i | write_i;

	// One wait cycle, then the answer; master drops its request after it
	always_comb
	begin
		next_state = state;
		unique case (state)
			crc_pkg::BUS_IDLE:
				if (request)
					next_state = crc_pkg::BUS_ANSWER;
			crc_pkg::BUS_ANSWER:
				next_state = crc_pkg::BUS_IDLE;
		endcase
	end

	always_ff @(posedge clock_i)
	begin
		if (reset_i)
			state <= crc_pkg::BUS_IDLE;
		else
			state <= next_state;
	end

	// Waitrequest stays high when idle so no request slips through
	assign capture_o = (state == crc_pkg::BUS_IDLE) & request;
	assign accept_o = (state == crc_pkg::BUS_ANSWER) & request;
	assign waitrequest_o = ~(state == crc_pkg::BUS_ANSWER);
endmodule

// file: tb/crc16_byte_engine_sva.sv
`timescale 1ns/1ps
module crc16_byte_engine_sva (
	input wire logic clock_i, // Clock
	input wire logic reset_i, // Reset
	input wire logic [4:0] address_i, // Addr
	input wire logic read_i, // Read
	input wire logic write_i, // Write
	input wire logic [31:0] writedata_i, // Wdata
	input wire logic [3:0] byteenable_i, // Lanes
	input wire logic [31:0] readdata_o, // Rdata
	input wire logic [1:0] response_o, // Resp
	input wire logic waitrequest_o // Stall
);
	// Completion edge and decode of the five words
	wire logic done = !waitrequest_o && (read_i || write_i);
	wire logic mapped = address_i[1:0] == 2'h0 && address_i < 5'h14;
	wire logic [7:0] keep = address_i == 5'h0c ? 8'h01 : 8'hff;
	default clocking @(posedge clock_i); endclocking
	default disable iff (reset_i);
	// Stored write, then at once a read of the same word
	sequence stored_wr;
		done && write_i && byteenable_i[0] && address_i < 5'h10;
	endsequence
	sequence same_rd;
		done && read_i && address_i == $past(address_i, 2);
	endsequence
	AST_READBACK: assert property (stored_wr ##2 same_rd
		|-> readdata_o[7:0] == ($past(writedata_i[7:0], 2) & keep)) else $error("readback");
	AST_ANSWER_NEXT: assert property ((read_i || write_i) && waitrequest_o |=> !waitrequest_o)
		else $error("late answer");
	AST_ONE_LOW: assert property (!waitrequest_o |=> waitrequest_o)
		else $error("long answer");
	AST_IDLE_HOLD: assert property (waitrequest_o && !read_i && !write_i |=> waitrequest_o)
		else $error("answer unasked");
	AST_BYTE_WIDE: assert property (done && read_i |-> readdata_o[31:8] == 24'h0)
		else $error("upper bits set");
	AST_CTRL_UPPER: assert property (done && read_i && address_i == 5'h0c |-> readdata_o[7:1] == 7'h0)
		else $error("control upper bits");
	AST_MAPPED_OK: assert property (done && mapped |-> response_o == crc_pkg::RESP_OKAY)
		else $error("bad okay");
	AST_UNMAPPED_ERR: assert property (done && !mapped |-> response_o == crc_pkg::RESP_SLAVEERROR)
		else $error("no error");
endmodule
bind crc16_byte_engine crc16_byte_engine_sva crc16_byte_engine_sva_i (.clock_i(clock_i), .reset_i(reset_i),
	.address_i(address_i), .read_i(read_i), .write_i(write_i), .writedata_i(writedata_i),
	.byteenable_i(byteenable_i), .readdata_o(readdata_o), .response_o(response_o), .waitrequest_o(waitrequest_o));

// file: tb/crc16_byte_engine_test.sv
`timescale 1ns/1ps
module crc16_byte_engine_test;
	logic clock_i = 1'b0;
	logic reset_i = 1'b1;
	logic read_i = 1'b0;
	logic write_i = 1'b0;
	logic sel = 1'b1;
	logic [4:0] address_i = 5'h00;
	logic [3:0] byteenable_i = 4'h0;
	logic [31:0] writedata_i = 32'h0;
	logic [31:0] readdata_o;
	logic [31:0] q;
	logic [31:0] lfsr = 32'h7e6a;
	logic [1:0] response_o;
	logic waitrequest_o;
	logic [15:0] sum = 16'h5c43;
	logic [15:0] vec [2][4] = '{'{16'hff9f, 16'hbbc3, 16'ha367, 16'hd0fa}, '{16'h0110, 16'h91f1, 16'hf2de, 16'h5c43}};
	int fail_count = 0;
	int checks = 0;
	// 50 MHz
	always #10 clock_i = ~clock_i;
	crc16_byte_engine crc16_byte_engine_i (.clock_i(clock_i), .reset_i(reset_i), .address_i(address_i),
		.read_i(read_i), .write_i(write_i), .writedata_i(writedata_i), .byteenable_i(byteenable_i),
		.readdata_o(readdata_o), .response_o(response_o), .waitrequest_o(waitrequest_o));
	// Galois shift, taps c5
	function automatic logic [31:0] next_rand(input logic [31:0] v);
		return {v[30:0], 1'b0} ^ (v[31] ? 32'hc5 : 32'h0);
	endfunction
	// Expected fold of one byte, MSB first
	function automatic logic [15:0] fold(input logic [15:0] s, input logic [7:0] b, input logic g);
		logic [15:0] t;
		t = {s[15:8] ^ b, s[7:0]};
		for (int i = 0; i < 8; i++)
			t = {t[14:0], 1'b0} ^ (t[15] ? (g ? 16'h8005 : 16'h1021) : 16'h0);
		return t;
	endfunction
	task check(input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp)
		begin
			fail_count++;
			$display("Error %0t: saw %h, want %h", $time, seen, exp);
		end
	endtask
	// Request held until the stall is seen low; release is left to the next call
	task bus(input logic w, input logic [4:0] a, input logic [31:0] d, input logic [3:0] be);
		address_i <= a;
		write_i <= w;
		read_i <= !w;
		writedata_i <= d;
		byteenable_i <= be;
		@(posedge clock_i);
		while (waitrequest_o !== 1'b0)
			@(posedge clock_i);
		q = readdata_o;
	endtask
	// Checksum as one word
	task sum_rd;
		logic [7:0] h;
		bus(1'b0, 5'h08, lfsr, 4'hf);
		h = q[7:0];
		bus(1'b0, 5'h04, lfsr, 4'hf);
		q = {16'h0, h, q[7:0]};
	endtask
	task stop_test;
		$display("Checks %0d, mismatches %0d", checks, fail_count);
		if (fail_count == 0 && checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	// Watchdog, well past the expected run
	initial
	begin
		#200000;
		fail_count++;
		stop_test;
	end
	initial
	begin
		repeat (16) @(posedge clock_i);
		reset_i <= 1'b0;
		@(posedge clock_i);
		for (int a = 0; a < 5; a++)
		begin
			bus(1'b0, 5'(a * 4), lfsr, 4'hf);
			check(q, 32'h0);
		end
		$display("Reset test done");
		// Upper control bits read zero; lane 0 off writes nothing
		bus(1'b1, 5'h0c, 32'hff, 4'hf);
		bus(1'b0, 5'h0c, lfsr, 4'hf);
		check(q, 32'h1);
		bus(1'b1, 5'h0c, 32'h0, 4'he);
		bus(1'b0, 5'h0c, lfsr, 4'hf);
		check(q, 32'h1);
		bus(1'b0, 5'h14, lfsr, 4'hf);
		check({q[31:2], response_o}, 32'(crc_pkg::RESP_SLAVEERROR));
		$display("Control test done");
		for (int g = 0; g < 2; g++)
		begin
			bus(1'b1, 5'h0c, 32'(g), 4'h1);
			bus(1'b1, 5'h04, 32'h0, 4'h1);
			bus(1'b1, 5'h08, 32'h0, 4'h1);
			bus(1'b1, 5'h00, 32'h1, 4'h1);
			sum_rd;
			check(q, g ? 32'h8005 : 32'h1021);
			bus(1'b1, 5'h08, 32'h0, 4'h1);
			bus(1'b1, 5'h04, 32'h0, 4'h1);
			for (int k = 0; k < 4; k++)
			begin
				bus(1'b1, 5'h00, 32'(8'h78 - 8'(k) * 8'h22), 4'h1);
				sum_rd;
				check(q, {16'h0, vec[g][k]});
			end
			bus(1'b0, 5'h10, lfsr, 4'hf);
			check(q, 32'h4);
		end
		$display("Vector test done");
		// Random bytes chained from the last vector sum
		for (int n = 0; n < 150; n++)
		begin
			lfsr = next_rand(lfsr);
			if (lfsr[2:0] == 3'h0)
			begin
				sel = lfsr[8];
				bus(1'b1, 5'h0c, lfsr >> 8, 4'h1);
			end
			else if (lfsr[2:0] == 3'h1)
			begin
				sum = lfsr[23:8];
				bus(1'b1, 5'h04, lfsr >> 8, 4'h1);
				bus(1'b1, 5'h08, lfsr >> 16, 4'h1);
			end
			else
			begin
				sum = fold(sum, lfsr[15:8], sel);
				bus(1'b1, 5'h00, lfsr >> 8, 4'hf);
				bus(1'b0, 5'h00, lfsr, 4'hf);
				check(q, {24'h0, lfsr[15:8]});
				sum_rd;
				check(q, {16'h0, sum});
			end
		end
		read_i <= 1'b0;
		write_i <= 1'b0;
		@(posedge clock_i);
		$display("Random test done");
		stop_test;
	end
endmodule
